//--- hdl/vic_defs.svh
// Offsets, field positions, reset values and vectors of the interrupt controller
`ifndef VIC_DEFS_SVH
`define VIC_DEFS_SVH

`define VIC_ADR_W 8
`define VIC_PC_W 13
`define VIC_NSRC 8

`define VIC_OFF_CTRL_A 8'h00
`define VIC_OFF_CTRL_B 8'h04
`define VIC_OFF_CTRL_C 8'h08
`define VIC_OFF_GRP0 8'h0c
`define VIC_OFF_GRP1 8'h10
`define VIC_OFF_GRP2 8'h14
`define VIC_OFF_EDGE 8'h18
`define VIC_OFF_STAT 8'h1c

`define VIC_A_GRP0_F 6
`define VIC_A_CMP_F 5
`define VIC_A_PIN_F 4
`define VIC_A_GRP0_E 3
`define VIC_A_CMP_E 2
`define VIC_A_PIN_E 1
`define VIC_A_GIE 0

`define VIC_B_TB0_F 7
`define VIC_B_CONV_F 6
`define VIC_B_GRP2_F 5
`define VIC_B_GRP1_F 4
`define VIC_B_TB0_E 3
`define VIC_B_CONV_E 2
`define VIC_B_GRP2_E 1
`define VIC_B_GRP1_E 0

`define VIC_C_TB1_F 4
`define VIC_C_TB1_E 0

`define VIC_G0_T1A 7
`define VIC_G0_T1P 6
`define VIC_G0_T0A 5
`define VIC_G0_T0P 4
`define VIC_G1_T2B 6
`define VIC_G1_T2A 5
`define VIC_G1_T2P 4
`define VIC_G2_EE 5
`define VIC_G2_LV 4

`define VIC_MEM_FLAG_LSB 4
`define VIC_MEM_W 4

`define VIC_IMPL_A 8'h7f
`define VIC_IMPL_B 8'hff
`define VIC_IMPL_C 8'h11
`define VIC_IMPL_G0 8'hff
`define VIC_IMPL_G1 8'h77
`define VIC_IMPL_G2 8'h33
`define VIC_IMPL_EDGE 8'h03

`define VIC_RST_REG 8'h00
`define VIC_RST_EDGE 2'h3
`define VIC_EDGE_RISE 0
`define VIC_EDGE_FALL 1

`define VIC_PRI_PIN 0
`define VIC_PRI_CMP 1
`define VIC_PRI_GRP0 2
`define VIC_PRI_GRP1 3
`define VIC_PRI_GRP2 4
`define VIC_PRI_CONV 5
`define VIC_PRI_TB0 6
`define VIC_PRI_TB1 7

`define VIC_VEC_BASE 13'h0004
`define VIC_VEC_STEP 13'h0004

`endif

//--- hdl/vic_pkg.sv
// Types shared by the interrupt controller
package vic_pkg;

	typedef struct packed {
		logic pin_level;
		logic cmp_evt;
		logic conv_evt;
		logic tb0_evt;
		logic tb1_evt;
		logic tmr0_p_evt;
		logic tmr0_a_evt;
		logic tmr1_p_evt;
		logic tmr1_a_evt;
		logic tmr2_p_evt;
		logic tmr2_a_evt;
		logic tmr2_b_evt;
		logic eeprom_evt;
		logic lowvolt_evt;
	} vic_src_t;

	typedef struct packed {
		logic insn_boundary;
		logic stack_full;
		logic return_from_interrupt;
		logic [12:0] pc_next;
	} vic_core_in_t;

	typedef struct packed {
		logic take;
		logic [12:0] vector;
		logic [12:0] push_data;
		logic pop;
		logic wake;
	} vic_core_out_t;

endpackage : vic_pkg

//--- hdl/vic_top.sv
// Vectored interrupt controller with classic Wishbone register slave
`timescale 1ns/100ps
`include "vic_defs.svh"

// Notes on behaviour
// - A source event sets its request flag regardless of any enable bit.
// - A set flag causes a vector jump only while its own enable is 1.
// - Global enable at 0 blocks every interrupt.
// - Taking an interrupt pushes next-instruction PC, then loads the vector.
// - Return-from-interrupt pops the saved PC from the stack.
// - Servicing clears the global enable to block nesting.
// - Requests while globally blocked still set and hold their flags.
// - No interrupt is acknowledged while the stack is full.
// - Simultaneous requests are served in fixed priority; groups share vectors.
// - Any flag becoming set wakes the device from sleep or idle.
// - Control register A: group0, comparator, pin flags and enables, global enable.
// - Control register B: time base 0, converter, group 2, group 1 fields.
// - Control register C: time base 1 flag bit 4, enable bit 0.
// - Group 0 register: four timer flags high, matching enables low.
// - Group 1 register: timer 2 B, A, P flags and enables.
// - Group 2 register: EEPROM and low-voltage flags and enables.
// - Implemented bits read and write; unimplemented bits read zero.
// - Group flag sets from members; service clears only the group flag.
// - Servicing a direct source clears its own flag.
// - Pin flag edge select: off, rising, falling, both; resets to both.
module vic_top
	import vic_pkg::*;
(
	input wire logic clk_sys, // System clock, 10 MHz
	input wire logic reset_n, // Asynchronous reset, active low
	input wire logic wb_cyc_i, // Bus cycle
	input wire logic wb_stb_i, // Bus strobe
	input wire logic wb_we_i, // Write enable
	input wire logic [`VIC_ADR_W-1:0] wb_adr_i, // Byte address
	input wire logic [31:0] wb_dat_i, // Write data
	input wire logic [3:0] wb_sel_i, // Byte lanes
	output logic [31:0] wb_dat_o, // Read data
	output logic wb_ack_o, // Acknowledge
	input wire vic_src_t src_i, // Source events and pin level
	input wire vic_core_in_t core_i, // Sequencer status
	output vic_core_out_t core_o // Take, vector, push, pop, wake
);

	// ----------------------------------------
	// Functions
	// ----------------------------------------
	function automatic logic [7:0] vic_next(
		input logic [7:0] cur,
		input logic wr,
		input logic [7:0] wdata,
		input logic [7:0] impl,
		input logic [7:0] set,
		input logic [7:0] clr
	);
		logic [7:0] v;
		v = wr ? wdata : cur;
		v = v & ~clr;
		v = v | set; // Set wins over clear
		return v & impl;
	endfunction : vic_next

	function automatic logic vic_member_hit(
		input logic [7:0] set,
		input logic [7:0] cur
	);
		logic [`VIC_MEM_W-1:0] f;
		logic [`VIC_MEM_W-1:0] e;
		f = set[`VIC_MEM_FLAG_LSB +: `VIC_MEM_W];
		e = cur[`VIC_MEM_W-1:0];
		return |(f & e);
	endfunction : vic_member_hit

	function automatic logic [`VIC_PC_W-1:0] vic_vec(
		input logic [`VIC_NSRC-1:0] onehot
	);
		logic [`VIC_PC_W-1:0] v;
		v = '0;
		for (int i = 0; i < `VIC_NSRC; i++) begin
			if (onehot[i]) begin
				v = `VIC_VEC_BASE + `VIC_VEC_STEP * i[`VIC_PC_W-1:0];
			end
		end
		return v;
	endfunction : vic_vec

	// ----------------------------------------
	// Reset release
	// ----------------------------------------
	logic [1:0] rst_sync_q;
	logic rst_n;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end

	assign rst_n = rst_sync_q[1];

	// ----------------------------------------
	// Registers and bus decode
	// ----------------------------------------
	logic [7:0] ctrl_a_q;
	logic [7:0] ctrl_b_q;
	logic [7:0] ctrl_c_q;
	logic [7:0] grp0_q;
	logic [7:0] grp1_q;
	logic [7:0] grp2_q;
	logic [1:0] edge_sel_q;
	logic ack_q;
	logic [31:0] dat_q;
	logic wr_go;
	logic [7:0] wdat;
	logic [7:0] rdat;
	logic [`VIC_NSRC-1:0] pend;

	assign wr_go = wb_cyc_i & wb_stb_i & wb_we_i & ack_q & wb_sel_i[0];
	assign wdat = wb_dat_i[7:0];

	always_comb begin
		unique case (wb_adr_i)
			`VIC_OFF_CTRL_A: rdat = ctrl_a_q;
			`VIC_OFF_CTRL_B: rdat = ctrl_b_q;
			`VIC_OFF_CTRL_C: rdat = ctrl_c_q;
			`VIC_OFF_GRP0: rdat = grp0_q;
			`VIC_OFF_GRP1: rdat = grp1_q;
			`VIC_OFF_GRP2: rdat = grp2_q;
			`VIC_OFF_EDGE: rdat = {6'h00, edge_sel_q};
			`VIC_OFF_STAT: rdat = pend;
			default: rdat = 8'h00;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			dat_q <= 32'h0000_0000;
		end else if (wb_cyc_i & wb_stb_i & ~ack_q) begin
			dat_q <= {24'h00_0000, rdat};
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;

	// ----------------------------------------
	// Pin edge detection
	// ----------------------------------------
	logic pin_prev_q;
	logic pin_evt;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pin_prev_q <= 1'b0;
		end else begin
			pin_prev_q <= src_i.pin_level;
		end
	end

	always_comb begin
		pin_evt = (edge_sel_q[`VIC_EDGE_RISE] & src_i.pin_level & ~pin_prev_q)
			| (edge_sel_q[`VIC_EDGE_FALL] & ~src_i.pin_level & pin_prev_q);
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			edge_sel_q <= `VIC_RST_EDGE;
		end else if (wr_go && wb_adr_i == `VIC_OFF_EDGE) begin
			edge_sel_q <= wdat[1:0];
		end
	end

	// ----------------------------------------
	// Hardware set terms
	// ----------------------------------------
	logic [7:0] set_a;
	logic [7:0] set_b;
	logic [7:0] set_c;
	logic [7:0] set_g0;
	logic [7:0] set_g1;
	logic [7:0] set_g2;

	always_comb begin
		set_g0 = 8'h00;
		set_g0[`VIC_G0_T1A] = src_i.tmr1_a_evt;
		set_g0[`VIC_G0_T1P] = src_i.tmr1_p_evt;
		set_g0[`VIC_G0_T0A] = src_i.tmr0_a_evt;
		set_g0[`VIC_G0_T0P] = src_i.tmr0_p_evt;
	end

	always_comb begin
		set_g1 = 8'h00;
		set_g1[`VIC_G1_T2B] = src_i.tmr2_b_evt;
		set_g1[`VIC_G1_T2A] = src_i.tmr2_a_evt;
		set_g1[`VIC_G1_T2P] = src_i.tmr2_p_evt;
	end

	always_comb begin
		set_g2 = 8'h00;
		set_g2[`VIC_G2_EE] = src_i.eeprom_evt;
		set_g2[`VIC_G2_LV] = src_i.lowvolt_evt;
	end

	always_comb begin
		set_a = 8'h00;
		set_a[`VIC_A_GRP0_F] = vic_member_hit(set_g0, grp0_q);
		set_a[`VIC_A_CMP_F] = src_i.cmp_evt;
		set_a[`VIC_A_PIN_F] = pin_evt;
	end

	always_comb begin
		set_b = 8'h00;
		set_b[`VIC_B_TB0_F] = src_i.tb0_evt;
		set_b[`VIC_B_CONV_F] = src_i.conv_evt;
		set_b[`VIC_B_GRP2_F] = vic_member_hit(set_g2, grp2_q);
		set_b[`VIC_B_GRP1_F] = vic_member_hit(set_g1, grp1_q);
	end

	always_comb begin
		set_c = 8'h00;
		set_c[`VIC_C_TB1_F] = src_i.tb1_evt;
	end

	// ----------------------------------------
	// Priority and acceptance
	// ----------------------------------------
	logic [`VIC_NSRC-1:0] pick;
	logic take;
	logic [7:0] clr_a;
	logic [7:0] clr_b;
	logic [7:0] clr_c;

	always_comb begin
		pend = '0;
		pend[`VIC_PRI_PIN] = ctrl_a_q[`VIC_A_PIN_F] & ctrl_a_q[`VIC_A_PIN_E];
		pend[`VIC_PRI_CMP] = ctrl_a_q[`VIC_A_CMP_F] & ctrl_a_q[`VIC_A_CMP_E];
		pend[`VIC_PRI_GRP0] = ctrl_a_q[`VIC_A_GRP0_F] & ctrl_a_q[`VIC_A_GRP0_E];
		pend[`VIC_PRI_GRP1] = ctrl_b_q[`VIC_B_GRP1_F] & ctrl_b_q[`VIC_B_GRP1_E];
		pend[`VIC_PRI_GRP2] = ctrl_b_q[`VIC_B_GRP2_F] & ctrl_b_q[`VIC_B_GRP2_E];
		pend[`VIC_PRI_CONV] = ctrl_b_q[`VIC_B_CONV_F] & ctrl_b_q[`VIC_B_CONV_E];
		pend[`VIC_PRI_TB0] = ctrl_b_q[`VIC_B_TB0_F] & ctrl_b_q[`VIC_B_TB0_E];
		pend[`VIC_PRI_TB1] = ctrl_c_q[`VIC_C_TB1_F] & ctrl_c_q[`VIC_C_TB1_E];
	end

	// Lowest index is the lowest vector address
	assign pick = pend & (~pend + `VIC_NSRC'(1));

	assign take = core_i.insn_boundary
		& ctrl_a_q[`VIC_A_GIE]
		& ~core_i.stack_full
		& (|pend);

	always_comb begin
		clr_a = 8'h00;
		clr_b = 8'h00;
		clr_c = 8'h00;
		if (take) begin
			clr_a[`VIC_A_GIE] = 1'b1;
			clr_a[`VIC_A_PIN_F] = pick[`VIC_PRI_PIN];
			clr_a[`VIC_A_CMP_F] = pick[`VIC_PRI_CMP];
			clr_a[`VIC_A_GRP0_F] = pick[`VIC_PRI_GRP0];
			clr_b[`VIC_B_GRP1_F] = pick[`VIC_PRI_GRP1];
			clr_b[`VIC_B_GRP2_F] = pick[`VIC_PRI_GRP2];
			clr_b[`VIC_B_CONV_F] = pick[`VIC_PRI_CONV];
			clr_b[`VIC_B_TB0_F] = pick[`VIC_PRI_TB0];
			clr_c[`VIC_C_TB1_F] = pick[`VIC_PRI_TB1];
		end
	end

	// ----------------------------------------
	// Flag and enable storage
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_a_q <= `VIC_RST_REG;
		end else begin
			ctrl_a_q <= vic_next(ctrl_a_q, wr_go && wb_adr_i == `VIC_OFF_CTRL_A, wdat,
				`VIC_IMPL_A, set_a, clr_a);
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_b_q <= `VIC_RST_REG;
		end else begin
			ctrl_b_q <= vic_next(ctrl_b_q, wr_go && wb_adr_i == `VIC_OFF_CTRL_B, wdat,
				`VIC_IMPL_B, set_b, clr_b);
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_c_q <= `VIC_RST_REG;
		end else begin
			ctrl_c_q <= vic_next(ctrl_c_q, wr_go && wb_adr_i == `VIC_OFF_CTRL_C, wdat,
				`VIC_IMPL_C, set_c, clr_c);
		end
	end

	// Member flags are never cleared by servicing
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			grp0_q <= `VIC_RST_REG;
		end else begin
			grp0_q <= vic_next(grp0_q, wr_go && wb_adr_i == `VIC_OFF_GRP0, wdat,
				`VIC_IMPL_G0, set_g0, 8'h00);
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			grp1_q <= `VIC_RST_REG;
		end else begin
			grp1_q <= vic_next(grp1_q, wr_go && wb_adr_i == `VIC_OFF_GRP1, wdat,
				`VIC_IMPL_G1, set_g1, 8'h00);
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			grp2_q <= `VIC_RST_REG;
		end else begin
			grp2_q <= vic_next(grp2_q, wr_go && wb_adr_i == `VIC_OFF_GRP2, wdat,
				`VIC_IMPL_G2, set_g2, 8'h00);
		end
	end

	// ----------------------------------------
	// Wake-up from low-power modes
	// ----------------------------------------
	logic wake_d;

	// Only a flag going from 0 to 1 wakes; a preset flag stays quiet
	always_comb begin
		wake_d = |(set_a & ~ctrl_a_q & `VIC_IMPL_A)
			| |(set_b & ~ctrl_b_q & `VIC_IMPL_B)
			| |(set_c & ~ctrl_c_q & `VIC_IMPL_C)
			| |(set_g0 & ~grp0_q & `VIC_IMPL_G0)
			| |(set_g1 & ~grp1_q & `VIC_IMPL_G1)
			| |(set_g2 & ~grp2_q & `VIC_IMPL_G2);
	end

	// ----------------------------------------
	// Sequencer outputs
	// ----------------------------------------
	logic take_q;
	logic [`VIC_PC_W-1:0] vector_q;
	logic [`VIC_PC_W-1:0] push_q;
	logic pop_q;
	logic wake_q;
	assign core_o = {take_q, vector_q, push_q, pop_q, wake_q};

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			take_q <= 1'b0;
			vector_q <= '0;
			push_q <= '0;
		end else begin
			take_q <= take;
			if (take) begin
				vector_q <= vic_vec(pick);
				push_q <= core_i.pc_next;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pop_q <= 1'b0;
		end else begin
			pop_q <= core_i.return_from_interrupt;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wake_q <= 1'b0;
		end else begin
			wake_q <= wake_d;
		end
	end

endmodule : vic_top

//--- testbench/vic_core_model.sv
// Sequencer and stack model facing the interrupt controller
`timescale 1ns/100ps
module vic_core_model
	import vic_pkg::*;
(
	input wire logic clk_sys, // Clock
	input wire logic reset_n, // Reset
	input wire logic slow, // Boundary every 4th cycle
	input wire logic full_req, // Hold stack full
	input wire logic return_from_interrupt_req, // Run a return
	input wire vic_core_out_t core_o, // From controller
	output vic_core_in_t core_i // To controller
);
	logic [1:0] ph_q;
	logic [2:0] depth_q;
	logic [12:0] pc_q;
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			ph_q <= 2'h0;
			pc_q <= 13'h100;
			depth_q <= 3'h0;
		end else begin
			ph_q <= ph_q + 2'h1;
			pc_q <= core_o.take ? core_o.vector : pc_q + 13'h1;
			depth_q <= depth_q + {2'h0, core_o.take} - {2'h0, core_o.pop};
		end
	end
	assign core_i.insn_boundary = !slow || ph_q == 2'h0;
	assign core_i.stack_full = full_req || depth_q == 3'h4;
	assign core_i.return_from_interrupt = return_from_interrupt_req && depth_q != 3'h0;
	assign core_i.pc_next = pc_q;
endmodule : vic_core_model

//--- testbench/vic_props.sv
// Port checker for the interrupt controller
`timescale 1ns/100ps
module vic_props
	import vic_pkg::*;
(
	input wire logic clk_sys, // Clock
	input wire logic reset_n, // Reset
	input wire logic wb_cyc_i, // Cycle
	input wire logic wb_stb_i, // Strobe
	input wire logic wb_we_i, // Write
	input wire logic [31:0] wb_dat_o, // Read data
	input wire logic wb_ack_o, // Ack
	input wire vic_src_t src_i, // Sources
	input wire vic_core_in_t core_i, // Core status
	input wire vic_core_out_t core_o // Core controls
);
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_take;
		core_o.take;
	endsequence
	property p_ack;
		s_req |=> wb_ack_o ##1 !wb_ack_o;
	endproperty
	a_ack: assert property (p_ack) else $error("bus answer late or long");
	property p_hi;
		wb_ack_o |-> wb_dat_o[31:8] == 24'h0;
	endproperty
	a_hi: assert property (p_hi) else $error("upper read bits set");
	property p_gate;
		s_take |-> $past(core_i.insn_boundary && !core_i.stack_full);
	endproperty
	a_gate: assert property (p_gate) else $error("take off boundary");
	property p_full;
		core_i.stack_full |=> !core_o.take;
	endproperty
	a_full: assert property (p_full) else $error("take with full stack");
	property p_push;
		s_take |-> core_o.push_data == $past(core_i.pc_next);
	endproperty
	a_push: assert property (p_push) else $error("pushed address wrong");
	property p_vec;
		s_take |-> core_o.vector[1:0] == 2'h0 && core_o.vector >= 13'h004 && core_o.vector <= 13'h020;
	endproperty
	a_vec: assert property (p_vec) else $error("vector out of table");
	property p_once;
		s_take ##1 (!(wb_cyc_i && wb_we_i))[*4] |-> !core_o.take;
	endproperty
	a_once: assert property (p_once) else $error("nested take");
	property p_pop;
		core_i.return_from_interrupt |=> core_o.pop;
	endproperty
	a_pop: assert property (p_pop) else $error("no pop after return");
	property p_wake;
		core_o.wake |-> $past(src_i[12:0] != 13'h0) || $past(src_i.pin_level) != $past(src_i.pin_level, 2);
	endproperty
	a_wake: assert property (p_wake) else $error("wake without event");
endmodule : vic_props
bind vic_top vic_props vic_props_i (.clk_sys(clk_sys), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.src_i(src_i), .core_i(core_i), .core_o(core_o));

//--- testbench/vic_top_bench.sv
// Self-checking bench for the interrupt controller
`timescale 1ns/100ps
module vic_top_bench
	import vic_pkg::*;
;
	logic clk_sys, reset_n, wb_cyc, wb_stb, wb_we, wb_ack_o, slow, full_req, return_from_interrupt_req;
	logic [7:0] wb_adr, q;
	logic [31:0] wb_dat, wb_dat_o;
	logic [3:0] wb_sel, sel_lane;
	vic_src_t src;
	vic_core_in_t core_i;
	vic_core_out_t core_o;
	int n_mismatch, comparisons;
	logic [23:0] rows [9] = '{24'h00fe7e, 24'h04ffff, 24'h08ff11, 24'h0cffff, 24'h10ff77,
		24'h14ff33, 24'h18ff03, 24'h1cff00, 24'h20ff00};
	vic_top vic_top_i (.clk_sys(clk_sys), .reset_n(reset_n), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_dat_i(wb_dat), .wb_sel_i(wb_sel),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .src_i(src), .core_i(core_i), .core_o(core_o));
	vic_core_model vic_core_model_i (.clk_sys(clk_sys), .reset_n(reset_n), .slow(slow),
		.full_req(full_req), .return_from_interrupt_req(return_from_interrupt_req), .core_o(core_o), .core_i(core_i));
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	task automatic close_out;
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : close_out
	task automatic chk(input logic [12:0] got, input logic [12:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic xfer(input logic we, input logic [7:0] adr, input logic [7:0] d);
		int n;
		n = 0;
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_sel <= sel_lane;
		wb_adr <= adr;
		wb_dat <= {24'h0, d};
		@(posedge clk_sys);
		while (wb_ack_o !== 1'b1) begin
			n++;
			if (n > 9) begin
				n_mismatch++;
				close_out();
			end
			@(posedge clk_sys);
		end
		q = wb_dat_o[7:0];
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		@(posedge clk_sys);
	endtask : xfer
	task automatic rd(input logic [7:0] adr, input logic [7:0] exp);
		xfer(1'b0, adr, 8'h00);
		chk({5'h0, q}, {5'h0, exp});
	endtask : rd
	task automatic pulse(input logic [13:0] m, input logic exp_wake);
		src <= vic_src_t'(src | m);
		@(posedge clk_sys);
		src <= vic_src_t'(src & ~m);
		@(posedge clk_sys);
		chk({12'h0, core_o.wake}, {12'h0, exp_wake});
	endtask : pulse
	task automatic await(input logic pop, input logic want, input logic [12:0] vec);
		logic seen;
		seen = 1'b0;
		for (int i = 0; i < 16; i++) begin
			@(posedge clk_sys);
			if (!seen && (pop ? core_o.pop : core_o.take) === 1'b1) begin
				seen = 1'b1;
				if (!pop) chk(core_o.vector, vec);
			end
		end
		chk({12'h0, seen}, {12'h0, want});
		if (seen !== want) close_out();
	endtask : await
	task automatic ret;
		return_from_interrupt_req <= 1'b1;
		@(posedge clk_sys);
		return_from_interrupt_req <= 1'b0;
		await(1'b1, 1'b1, 13'h0);
	endtask : ret
	// ------
	// Main sequence
	// ------
	initial begin
		{reset_n, wb_cyc, wb_stb, wb_we, slow, full_req, return_from_interrupt_req} = 7'h0;
		{wb_adr, wb_dat, src} = '0;
		wb_sel = 4'h0;
		sel_lane = 4'h1;
		n_mismatch = 0;
		comparisons = 0;
		repeat (5) @(posedge clk_sys);
		reset_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		foreach (rows[i]) begin
			xfer(1'b1, rows[i][23:16], rows[i][15:8]);
			rd(rows[i][23:16], rows[i][7:0]);
			xfer(1'b1, rows[i][23:16], 8'h00);
		end
		sel_lane = 4'h0;
		xfer(1'b1, 8'h00, 8'h7e);
		sel_lane = 4'h1;
		rd(8'h00, 8'h00);
		pulse(14'h1600, 1'b1);
		rd(8'h00, 8'h20);
		rd(8'h04, 8'h80);
		rd(8'h08, 8'h10);
		xfer(1'b1, 8'h00, 8'h21);
		await(1'b0, 1'b0, 13'h0);
		xfer(1'b1, 8'h00, 8'h20);
		xfer(1'b1, 8'h04, 8'h88);
		xfer(1'b1, 8'h08, 8'h11);
		xfer(1'b1, 8'h00, 8'h24);
		await(1'b0, 1'b0, 13'h0);
		xfer(1'b1, 8'h00, 8'h25);
		await(1'b0, 1'b1, 13'h008);
		rd(8'h00, 8'h04);
		xfer(1'b1, 8'h00, 8'h05);
		await(1'b0, 1'b1, 13'h01c);
		rd(8'h04, 8'h08);
		ret();
		ret();
		slow <= 1'b1;
		full_req <= 1'b1;
		xfer(1'b1, 8'h00, 8'h01);
		await(1'b0, 1'b0, 13'h0);
		full_req <= 1'b0;
		await(1'b0, 1'b1, 13'h020);
		rd(8'h08, 8'h01);
		ret();
		slow <= 1'b0;
		xfer(1'b1, 8'h0c, 8'h01);
		xfer(1'b1, 8'h00, 8'h08);
		pulse(14'h0120, 1'b1);
		rd(8'h0c, 8'h91);
		rd(8'h00, 8'h48);
		xfer(1'b1, 8'h00, 8'h49);
		await(1'b0, 1'b1, 13'h00c);
		rd(8'h00, 8'h08);
		rd(8'h0c, 8'h91);
		ret();
		for (int m = 0; m < 4; m++) begin
			xfer(1'b1, 8'h18, 8'(m));
			xfer(1'b1, 8'h00, 8'h00);
			src.pin_level <= 1'b1;
			@(posedge clk_sys);
			rd(8'h00, {3'h0, m[0], 4'h0});
			xfer(1'b1, 8'h00, 8'h00);
			src.pin_level <= 1'b0;
			@(posedge clk_sys);
			rd(8'h00, {3'h0, m[1], 4'h0});
		end
		xfer(1'b1, 8'h04, 8'h80);
		pulse(14'h0400, 1'b0);
		reset_n <= 1'b0;
		repeat (5) @(posedge clk_sys);
		reset_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		foreach (rows[i]) rd(rows[i][23:16], rows[i][23:16] == 8'h18 ? 8'h03 : 8'h00);
		close_out();
	end
endmodule : vic_top_bench
